//--- bench/sdcc_core_chk.sv
// sdcc_core_chk: port assertions for the conversion control block
`timescale 1ns/100ps
`default_nettype none
module sdcc_core_chk
  import sdcc_pkg::*;
(
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  // register port
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  // analog controls
  input wire logic        burnout_enable_bit,
  input wire logic        offset_dac_sign,
  input wire logic [6:0]  offset_dac_magnitude,
  input wire logic        offset_dac_load,
  // result stream
  input wire logic        res_valid,
  input wire logic        res_ready,
  input wire logic [24:0] res_data
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // ---------------------------------------------------------------
  // offset dac
  // ---------------------------------------------------------------
  property p_dac_load;
    offset_dac_load |-> $past(reg_wr && reg_addr == SDCC_A_DAC);
  endproperty
  a_dac_load: assert property (p_dac_load) else $error("dac load without write");
  property p_dac_val;
    offset_dac_load |-> {offset_dac_sign, offset_dac_magnitude} == $past(reg_wdata);
  endproperty
  a_dac_val: assert property (p_dac_val) else $error("dac level differs from write");
  property p_dac_hold;
    !$past(reg_wr) |-> $stable({offset_dac_sign, offset_dac_magnitude});
  endproperty
  a_dac_hold: assert property (p_dac_hold) else $error("dac level moved alone");
  // ---------------------------------------------------------------
  // burnout, reads and stream
  // ---------------------------------------------------------------
  property p_bce_rise;
    $rose(burnout_enable_bit) |-> $past(reg_wr && reg_addr == SDCC_A_CTRL && reg_wdata[SDCC_B_BCE]);
  endproperty
  a_bce_rise: assert property (p_bce_rise) else $error("burnout on without write");
  property p_bce_fall;
    $fell(burnout_enable_bit) |-> $past(reg_wr && reg_addr == SDCC_A_CTRL);
  endproperty
  a_bce_fall: assert property (p_bce_fall) else $error("burnout off without write");
  property p_rd_idle;
    !reg_rd |-> reg_rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data without strobe");
  property p_unmapped;
    reg_rd && reg_addr == 8'h00 |-> reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_hold;
    res_valid && !res_ready |=> res_valid && $stable(res_data);
  endproperty
  a_hold: assert property (p_hold) else $error("stream word dropped while stalled");
endmodule
bind sdcc_core sdcc_core_chk u_chk (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .burnout_enable_bit(burnout_enable_bit), .offset_dac_sign(offset_dac_sign),
  .offset_dac_magnitude(offset_dac_magnitude), .offset_dac_load(offset_dac_load),
  .res_valid(res_valid), .res_ready(res_ready), .res_data(res_data));
`default_nettype wire

//--- bench/sdcc_mod_src.sv
// sdcc_mod_src: behavioural modulator bitstream source
`timescale 1ns/100ps
`default_nettype none
module sdcc_mod_src (
  // clock
  input wire logic       sys_clk,
  // density: 0 none, 1 full, 2 half
  input wire logic [1:0] level,
  // bitstream
  output logic           mod_bit
);
  logic ph_r = 1'b0;
  // half density pattern
  always_ff @(posedge sys_clk) begin
    ph_r <= ~ph_r;
  end
  // pick the density
  assign mod_bit = (level == 2'h2) ? ph_r : level[0];
endmodule
`default_nettype wire

//--- bench/tb.sv
// tb: self-checking bench for the conversion control block
`timescale 1ns/100ps
`default_nettype none
module tb import sdcc_pkg::*; ;
  logic        sys_clk, sys_rst, reg_wr, reg_rd, res_ready, mod_bit;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic [1:0]  level;
  logic        mclk, bce, dsign, dload, vext, res_valid;
  logic [6:0]  dmag;
  logic [2:0]  gain;
  logic [24:0] res_data;
  int          n_fail = 0;
  int          n_compared = 0;
  int          cyc = 0;
  sdcc_mod_src src (.sys_clk(sys_clk), .level(level), .mod_bit(mod_bit));
  sdcc_core dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mod_bit(mod_bit),
    .cal_range_err(1'b0), .modulator_clk(mclk), .burnout_enable_bit(bce), .offset_dac_sign(dsign),
    .offset_dac_magnitude(dmag), .offset_dac_load(dload), .pga_gain(gain), .vref_external(vext),
    .res_valid(res_valid), .res_ready(res_ready), .res_data(res_data));
  // clock and cycle count
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) cyc <= cyc + 1;
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [24:0] got, input logic [24:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_win(input int v, input int lo, input int hi);
    n_compared++;
    if (v < lo || v > hi) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h to %h", $time, v, lo, hi);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    // let the written register settle before anyone looks at outputs
    @(negedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    // take the read data at the rising edge that ends the access
    @(posedge sys_clk);
    d = reg_rdata;
    reg_rd <= 1'b0;
  endtask
  task automatic rd24(input logic [7:0] a, input logic [23:0] exp);
    logic [7:0] h, m, l;
    rd(a, h);
    rd(a + 8'h01, m);
    rd(a + 8'h02, l);
    chk({1'b0, h, m, l}, {1'b0, exp});
  endtask
  task automatic run(input logic [7:0] mode, input int lo, input int hi);
    int t0;
    logic [7:0] s;
    wr(SDCC_A_STA, 8'h00);
    wr(SDCC_A_MODE, mode);
    t0 = cyc;
    rd(SDCC_A_STA, s);
    chk(25'(s[SDCC_B_BUSY]), 25'h1);
    while (s[SDCC_B_DONE] !== 1'b1 && cyc - t0 < hi) rd(SDCC_A_STA, s);
    chk_win(cyc - t0, lo, hi);
    rd(SDCC_A_MODE, s);
    chk(25'(s), 25'h80);
    rd(SDCC_A_STA, s);
    chk(25'(s[SDCC_B_BUSY]), 25'h0);
  endtask
  task automatic pop(input logic [24:0] exp);
    chk(res_data, exp);
    @(posedge sys_clk);
    res_ready <= 1'b1;
    @(posedge sys_clk);
    res_ready <= 1'b0;
  endtask
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (60000) @(posedge sys_clk);
    n_fail++;
    complete_run();
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [7:0] d;
    int n;
    sys_rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    res_ready = 1'b0;
    level = 2'h0;
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd(SDCC_A_CTRL, d);
    chk(25'(d), 25'(SDCC_CTRL_RST));
    rd(SDCC_A_CFG, d);
    chk(25'(d), 25'(SDCC_CFG_RST));
    rd(SDCC_A_DAC, d);
    chk(25'(d), 25'(SDCC_DAC_RST));
    rd(8'h00, d);
    chk(25'(d), 25'h0);
    wr(SDCC_A_DAC, 8'h85);
    chk({dsign, dmag}, 25'h85);
    rd(SDCC_A_DAC, d);
    chk(25'(d), 25'h85);
    wr(SDCC_A_CTRL, 8'h18);
    chk(25'(bce), 25'h1);
    chk(25'(gain), 25'h0);
    chk(25'(vext), 25'h0);
    wr(SDCC_A_CTRL, 8'h00);
    chk(25'(bce), 25'h0);
    wr(SDCC_A_DECH, 8'h00);
    wr(SDCC_A_DECL, 8'h13);
    wr(SDCC_A_CFG, 8'h10);
    run(8'h82, 2550, 2660);
    rd24(SDCC_A_FH, 24'h000000);
    pop({1'b1, 24'h000000});
    wr(SDCC_A_CTRL, 8'h10);
    wr(SDCC_A_CFG, 8'h00);
    run(8'h82, 7650, 7780);
    rd24(SDCC_A_FH, 24'h800000);
    rd24(SDCC_A_SH, 24'h800000);
    pop({1'b0, 24'h800000});
    wr(SDCC_A_CFG, 8'h10);
    wr(SDCC_A_MODE, 8'h83);
    repeat (6 * 2560 + 100) @(posedge sys_clk);
    rd(SDCC_A_STA, d);
    chk(25'(d & 8'hAC), 25'hAC);
    wr(SDCC_A_MODE, 8'h80);
    rd(SDCC_A_STA, d);
    chk(25'(d[SDCC_B_BUSY]), 25'h0);
    n = 0;
    res_ready <= 1'b1;
    repeat (8) begin
      @(posedge sys_clk);
      if (res_valid === 1'b1) n++;
    end
    res_ready <= 1'b0;
    chk(25'(n), 25'h4);
    complete_run();
  end
endmodule
`default_nettype wire

//--- core/sdcc_core.sv
// sdcc_core: conversion sequencing, filters, result and status registers
`timescale 1ns/100ps
`default_nettype none
module sdcc_core
  import sdcc_pkg::*;
#(
  parameter int FIFO_DEPTH = 4
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_rd,
  output logic [7:0]       reg_rdata,
  // modulator bitstream from analog front end
  input  wire logic        mod_bit,
  input  wire logic        cal_range_err,
  // analog controls
  output logic             modulator_clk,
  output logic             burnout_enable_bit,
  output logic             offset_dac_sign,
  output logic [6:0]       offset_dac_magnitude,
  output logic             offset_dac_load,
  output logic [2:0]       pga_gain,
  output logic             vref_external,
  // result stream out (bit 24 flags fast filter)
  output logic             res_valid,
  input  wire logic        res_ready,
  output logic [24:0]      res_data
);
  // -------------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------------
  typedef enum logic [2:0] {
    SDCC_IDLE = 3'b001,
    SDCC_CONV = 3'b010,
    SDCC_CAL  = 3'b100
  } sdcc_state_t;

  sdcc_state_t  st_r;
  logic [7:0]   ctrl_r;
  logic [7:0]   cfg_r;
  logic [2:0]   system_mode_field_r;
  logic         enable_r;
  logic [7:0]   clkdiv_r;
  logic [10:0]  deci_r;
  logic [7:0]   offset_dac_setting_r;
  logic [23:0]  slow_res_r;
  logic [23:0]  fast_res_r;
  logic         conversion_done_flag_r;
  logic         overrun_flag_r;
  logic         slow_filter_clip_flag_r;
  logic         fast_filter_clip_flag_r;
  logic         cal_err_r;
  logic         mod_s1_r;
  logic         mod_s2_r;
  logic         cal_s1_r;
  logic         cal_s2_r;
  logic [7:0]   div_cnt_r;
  logic         mdclk_r;
  logic [6:0]   osr_cnt_r;
  logic [10:0]  dec_cnt_r;
  logic [1:0]   periods_r;
  logic [25:0]  acc_r;
  logic [25:0]  hist_r [3];
  logic         acc_ovf_r;
  logic         slow_ovf_r;

  logic         mode_wr;
  logic         md_tick;
  logic         sample_tick;
  logic         period_end;
  logic         conv_busy;
  logic         slow_ready;
  logic         sel_done;
  logic         done_clr;
  logic [10:0]  deci_eff;
  logic [26:0]  acc_sum;
  logic [27:0]  slow_sum;
  logic [23:0]  fast_word;
  logic [23:0]  slow_word;
  logic         fifo_in_ready;
  logic         fifo_push;

  // -------------------------------------------------------------------------
  // register writes
  // -------------------------------------------------------------------------
  assign mode_wr  = reg_wr && (reg_addr == SDCC_A_MODE);
  assign done_clr = reg_wr && (reg_addr == SDCC_A_STA) && !reg_wdata[SDCC_B_DONE];

  // configuration registers, only changed while idle
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ctrl_r   <= SDCC_CTRL_RST;
      cfg_r    <= SDCC_CFG_RST;
      clkdiv_r <= SDCC_CLK_RST;
      deci_r   <= SDCC_DEC_RST;
    end else if (reg_wr && st_r == SDCC_IDLE) begin
      unique case (reg_addr)
        SDCC_A_CTRL:   ctrl_r <= {3'h0, reg_wdata[4:0]};
        SDCC_A_CFG:    cfg_r <= {3'h0, reg_wdata[4], 1'b0, reg_wdata[2], 2'h0};
        SDCC_A_CLKDIV: clkdiv_r <= reg_wdata;
        SDCC_A_DECH:   deci_r[10:8] <= reg_wdata[2:0];
        SDCC_A_DECL:   deci_r[7:0] <= reg_wdata;
        default: ;
      endcase
    end
  end

  // offset dac setting; every write while idle loads the dac
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      offset_dac_setting_r <= SDCC_DAC_RST;
      offset_dac_load      <= 1'b0;
    end else begin
      offset_dac_load <= 1'b0;
      if (reg_wr && reg_addr == SDCC_A_DAC && st_r == SDCC_IDLE) begin
        offset_dac_setting_r <= reg_wdata;
        offset_dac_load      <= 1'b1;
      end
    end
  end

  // mode register; hardware returns single mode to idle
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      system_mode_field_r <= SDCC_SM_IDLE;
      enable_r            <= 1'b0;
    end else if (mode_wr) begin
      enable_r            <= reg_wdata[SDCC_B_EN];
      system_mode_field_r <= reg_wdata[SDCC_B_EN] ? reg_wdata[2:0] : SDCC_SM_IDLE;
    end else if (sel_done && system_mode_field_r == SDCC_SM_SINGLE) begin
      system_mode_field_r <= SDCC_SM_IDLE;
    end
  end

  // analog control outputs
  assign burnout_enable_bit   = ctrl_r[SDCC_B_BCE];
  assign offset_dac_sign      = offset_dac_setting_r[SDCC_B_DACS];
  assign offset_dac_magnitude = offset_dac_setting_r[6:0];
  assign pga_gain             = ctrl_r[2:0];
  assign vref_external        = cfg_r[2];
  assign modulator_clk        = mdclk_r;

  // -------------------------------------------------------------------------
  // input synchronisers
  // -------------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      mod_s1_r <= 1'b0;
      mod_s2_r <= 1'b0;
      cal_s1_r <= 1'b0;
      cal_s2_r <= 1'b0;
    end else begin
      mod_s1_r <= mod_bit;
      mod_s2_r <= mod_s1_r;
      cal_s1_r <= cal_range_err;
      cal_s2_r <= cal_s1_r;
    end
  end

  // -------------------------------------------------------------------------
  // modulator clock and conversion period timing
  // -------------------------------------------------------------------------
  assign md_tick     = (div_cnt_r == clkdiv_r);
  assign sample_tick = md_tick && (osr_cnt_r == SDCC_OSR);
  assign deci_eff    = (deci_r < SDCC_DEC_MIN) ? SDCC_DEC_MIN : deci_r;
  assign period_end  = sample_tick && (dec_cnt_r == deci_eff) && st_r == SDCC_CONV;

  // system clock divider
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      div_cnt_r <= '0;
      mdclk_r   <= 1'b0;
    end else begin
      div_cnt_r <= md_tick ? '0 : div_cnt_r + 1'b1;
      if (md_tick) begin
        mdclk_r <= ~mdclk_r;
      end
    end
  end

  // sample and decimation counters, restarted with each new run
  always_ff @(posedge sys_clk) begin
    if (sys_rst || mode_wr) begin
      osr_cnt_r <= '0;
      dec_cnt_r <= '0;
    end else if (st_r == SDCC_CONV && md_tick) begin
      osr_cnt_r <= osr_cnt_r + 1'b1;
      if (sample_tick) begin
        dec_cnt_r <= (dec_cnt_r == deci_eff) ? '0 : dec_cnt_r + 1'b1;
      end
    end
  end

  // -------------------------------------------------------------------------
  // sequencer
  // -------------------------------------------------------------------------
  assign conv_busy = (st_r != SDCC_IDLE);
  assign slow_ready = period_end && (periods_r == SDCC_SINC3_PERIODS - 2'h1);
  assign sel_done  = cfg_r[SDCC_B_ISEL] ? period_end : slow_ready;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_r <= SDCC_IDLE;
    end else if (mode_wr) begin
      // any mode write aborts what runs and restarts from scratch
      unique case (reg_wdata[2:0])
        SDCC_SM_IDLE:                st_r <= SDCC_IDLE;
        SDCC_SM_SINGLE, SDCC_SM_CONT: st_r <= reg_wdata[SDCC_B_EN] ? SDCC_CONV : SDCC_IDLE;
        default:                     st_r <= reg_wdata[SDCC_B_EN] ? SDCC_CAL : SDCC_IDLE;
      endcase
    end else if (st_r == SDCC_CONV && sel_done && system_mode_field_r == SDCC_SM_SINGLE) begin
      st_r <= SDCC_IDLE;
    end
  end

  // count completed periods up to one below the slow filter depth
  always_ff @(posedge sys_clk) begin
    if (sys_rst || mode_wr) begin
      periods_r <= '0;
    end else if (period_end && periods_r != SDCC_SINC3_PERIODS - 2'h1) begin
      periods_r <= periods_r + 1'b1;
    end
  end

  // -------------------------------------------------------------------------
  // filters: fast integrates one period, slow sums the last three
  // -------------------------------------------------------------------------
  assign acc_sum  = {1'b0, acc_r} + 27'(mod_s2_r);
  assign slow_sum = {2'h0, hist_r[0]} + {2'h0, hist_r[1]} + {2'h0, hist_r[2]};

  always_ff @(posedge sys_clk) begin
    if (sys_rst || mode_wr) begin
      acc_r     <= '0;
      acc_ovf_r <= 1'b0;
    end else if (period_end) begin
      acc_r     <= '0;
      acc_ovf_r <= 1'b0;
    end else if (sample_tick) begin
      acc_r <= acc_sum[25:0];
      if (acc_sum[26]) begin
        acc_ovf_r <= 1'b1;
      end
    end
  end

  // three-period history of the fast sums
  for (genvar i = 0; i < 3; i++) begin : g_hist
    always_ff @(posedge sys_clk) begin
      if (sys_rst || mode_wr) begin
        hist_r[i] <= '0;
      end else if (period_end) begin
        hist_r[i] <= (i == 0) ? acc_r : hist_r[(i == 0) ? 0 : i-1];
      end
    end
  end

  assign slow_ovf_r = slow_sum[27];

  // take 24-bit words from the sums (slow sum divided by 4); bipolar flips the msb
  function automatic logic [23:0] sdcc_code(input logic [23:0] raw, input logic bip);
    sdcc_code = bip ? (raw ^ SDCC_MID) : raw;
  endfunction

  assign fast_word = sdcc_code(acc_r[23:0], ctrl_r[SDCC_B_POL]);
  assign slow_word = sdcc_code(slow_sum[25:2], ctrl_r[SDCC_B_POL]);

  // result registers written at every period end regardless of errors
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      fast_res_r <= '0;
      slow_res_r <= '0;
    end else if (period_end) begin
      fast_res_r <= fast_word;
      slow_res_r <= slow_word;
    end
  end

  // -------------------------------------------------------------------------
  // status flags; a set in the same cycle wins over a clear
  // -------------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      conversion_done_flag_r  <= 1'b0;
      overrun_flag_r          <= 1'b0;
      slow_filter_clip_flag_r <= 1'b0;
      fast_filter_clip_flag_r <= 1'b0;
      cal_err_r               <= 1'b0;
    end else begin
      if (sel_done) begin
        conversion_done_flag_r <= 1'b1;
      end else if (done_clr) begin
        conversion_done_flag_r <= 1'b0;
      end
      if (sel_done && conversion_done_flag_r) begin
        overrun_flag_r <= 1'b1;
      end else if (mode_wr) begin
        overrun_flag_r <= 1'b0;
      end
      if (period_end && slow_ovf_r) begin
        slow_filter_clip_flag_r <= 1'b1;
      end else if (mode_wr) begin
        slow_filter_clip_flag_r <= 1'b0;
      end
      if (period_end && acc_ovf_r) begin
        fast_filter_clip_flag_r <= 1'b1;
      end else if (mode_wr) begin
        fast_filter_clip_flag_r <= 1'b0;
      end
      if (st_r == SDCC_CAL && cal_s2_r) begin
        cal_err_r <= 1'b1;
      end else if (mode_wr) begin
        cal_err_r <= 1'b0;
      end
    end
  end

  // -------------------------------------------------------------------------
  // read mux
  // -------------------------------------------------------------------------
  always_comb begin
    reg_rdata = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        SDCC_A_CTRL:   reg_rdata = ctrl_r;
        SDCC_A_CFG:    reg_rdata = cfg_r;
        SDCC_A_MODE:   reg_rdata = {enable_r, 4'h0, system_mode_field_r};
        SDCC_A_CLKDIV: reg_rdata = clkdiv_r;
        SDCC_A_DECH:   reg_rdata = {5'h00, deci_r[10:8]};
        SDCC_A_DECL:   reg_rdata = deci_r[7:0];
        SDCC_A_DAC:    reg_rdata = offset_dac_setting_r;
        SDCC_A_STA: begin
          reg_rdata[SDCC_B_BUSY] = conv_busy;
          reg_rdata[SDCC_B_DONE] = conversion_done_flag_r;
          reg_rdata[SDCC_B_CALX] = cal_err_r;
          reg_rdata[SDCC_B_ERR]  = slow_filter_clip_flag_r | fast_filter_clip_flag_r
                                   | overrun_flag_r | cal_err_r;
          reg_rdata[SDCC_B_OVR]  = overrun_flag_r;
          reg_rdata[SDCC_B_S3C]  = slow_filter_clip_flag_r;
          reg_rdata[SDCC_B_FFC]  = fast_filter_clip_flag_r;
        end
        SDCC_A_SH: reg_rdata = slow_res_r[23:16];
        SDCC_A_SM: reg_rdata = slow_res_r[15:8];
        SDCC_A_SL: reg_rdata = slow_res_r[7:0];
        SDCC_A_FH: reg_rdata = fast_res_r[23:16];
        SDCC_A_FM: reg_rdata = fast_res_r[15:8];
        SDCC_A_FL: reg_rdata = fast_res_r[7:0];
        default:   reg_rdata = 8'h00;
      endcase
    end
  end

  // -------------------------------------------------------------------------
  // result stream: the selected filter's word at each done event
  // -------------------------------------------------------------------------
  assign fifo_push = sel_done;

  sdcc_fifo #(
    .W (25),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .in_valid  (fifo_push),
    .in_ready  (fifo_in_ready),
    .in_data   ({cfg_r[SDCC_B_ISEL], cfg_r[SDCC_B_ISEL] ? fast_word : slow_word}),
    .out_valid (res_valid),
    .out_ready (res_ready),
    .out_data  (res_data)
  );

  // unused: a full stream drops the word; the registers still hold it
  logic unused_ready;
  assign unused_ready = fifo_in_ready;
endmodule
`default_nettype wire

//--- core/sdcc_fifo.sv
// sdcc_fifo: small valid/ready word buffer
`timescale 1ns/100ps
`default_nettype none
module sdcc_fifo #(
  parameter int W = 25,
  parameter int D = 4
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         sys_rst,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem_r [D];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0]   cnt_r;
  logic          push;
  logic          pop;

  // handshakes
  assign in_ready  = (cnt_r != (AW+1)'(D));
  assign out_valid = (cnt_r != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_r[rp_r];

  // storage
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end

  // pointers and count
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == AW'(D-1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == AW'(D-1)) ? '0 : rp_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

//--- core/sdcc_pkg.sv
// sdcc_pkg: constants for the sigma-delta conversion control block
package sdcc_pkg;
  // -------------------------------------------------------------------------
  // system mode codes
  // -------------------------------------------------------------------------
  localparam logic [2:0] SDCC_SM_IDLE   = 3'h0;
  localparam logic [2:0] SDCC_SM_FULCAL = 3'h1;
  localparam logic [2:0] SDCC_SM_SINGLE = 3'h2;
  localparam logic [2:0] SDCC_SM_CONT   = 3'h3;
  localparam logic [2:0] SDCC_SM_OFFINT = 3'h4;
  localparam logic [2:0] SDCC_SM_GAININT = 3'h5;
  localparam logic [2:0] SDCC_SM_OFFSYS = 3'h6;
  localparam logic [2:0] SDCC_SM_GAINSYS = 3'h7;
  // -------------------------------------------------------------------------
  // register addresses (8-bit special function register space)
  // -------------------------------------------------------------------------
  localparam logic [7:0] SDCC_A_CTRL   = 8'hF4; // polarity, burnout, gain
  localparam logic [7:0] SDCC_A_CFG    = 8'hFB; // filter select
  localparam logic [7:0] SDCC_A_MODE   = 8'hF3; // system mode
  localparam logic [7:0] SDCC_A_CLKDIV = 8'hF7;
  localparam logic [7:0] SDCC_A_DECH   = 8'h9B;
  localparam logic [7:0] SDCC_A_DECL   = 8'h9A;
  localparam logic [7:0] SDCC_A_DAC    = 8'hBF;
  localparam logic [7:0] SDCC_A_STA    = 8'hE8; // status
  localparam logic [7:0] SDCC_A_SH     = 8'hE0; // slow result high
  localparam logic [7:0] SDCC_A_SM     = 8'hE1;
  localparam logic [7:0] SDCC_A_SL     = 8'hE2;
  localparam logic [7:0] SDCC_A_FH     = 8'hE3; // fast result high
  localparam logic [7:0] SDCC_A_FM     = 8'hE4;
  localparam logic [7:0] SDCC_A_FL     = 8'hE5;
  // -------------------------------------------------------------------------
  // field positions and reset values
  // -------------------------------------------------------------------------
  localparam int SDCC_B_POL   = 4;
  localparam int SDCC_B_BCE   = 3;
  localparam int SDCC_B_ISEL  = 4;
  localparam int SDCC_B_EN    = 7;
  localparam int SDCC_B_DACS  = 7;
  // status bits
  localparam int SDCC_B_BUSY  = 7;
  localparam int SDCC_B_DONE  = 5;
  localparam int SDCC_B_ERR   = 3;
  localparam int SDCC_B_OVR   = 2;
  localparam int SDCC_B_S3C   = 1;
  localparam int SDCC_B_FFC   = 0;
  localparam int SDCC_B_CALX  = 4; // calibration out of range input latch
  localparam logic [7:0]  SDCC_CTRL_RST = 8'h10;
  localparam logic [7:0]  SDCC_CFG_RST  = 8'h00;
  localparam logic [7:0]  SDCC_MODE_RST = 8'h00;
  localparam logic [7:0]  SDCC_DAC_RST  = 8'h00;
  localparam logic [7:0]  SDCC_CLK_RST  = 8'h00;
  localparam logic [10:0] SDCC_DEC_RST  = 11'h7FF;
  localparam logic [10:0] SDCC_DEC_MIN  = 11'h013; // smallest accepted ratio
  localparam logic [1:0]  SDCC_SINC3_PERIODS = 2'h3;
  localparam logic [6:0]  SDCC_OSR = 7'h7F; // modulator samples per tick - 1
  localparam logic [23:0] SDCC_MID = 24'h800000;
endpackage
